// ---- hdl/core_irq_power.sv ----
// Interrupt entry/exit, flag sets and wait/stop control of the core
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module core_irq_power #(
  parameter int PORT_PINS   = 22,
  parameter int STAB_CYCLES = irq_power_pkg::STAB_DEFAULT
) (
  // Clock and reset
  input  wire logic                            clk_i,
  input  wire logic                            reset_n_i,
  // APB slave
  input  wire logic                            psel_i,
  input  wire logic                            penable_i,
  input  wire logic                            pwrite_i,
  input  wire logic [7:0]                      paddr_i,
  input  wire logic [31:0]                     pwdata_i,
  input  wire logic [3:0]                      pstrb_i,
  output logic                                 pready_o,
  output logic                                 pslverr_o,
  output logic [31:0]                          prdata_o,
  // External pins
  input  wire logic                            nmi_pin_n_i,
  input  wire logic [PORT_PINS-1:0]            port_pin_i,
  input  wire logic [PORT_PINS-1:0]            port_irq_en_i,
  // Peripheral events and their enables
  input  wire irq_power_pkg::periph_event_type periph_event_i,
  input  wire irq_power_pkg::periph_event_type periph_en_i,
  // Instruction sequencer
  input  wire logic                            instr_end_i,
  input  wire logic [11:0]                     pc_i,
  input  wire logic                            return_from_interrupt_i,
  input  wire logic                            wait_exec_i,
  input  wire logic                            stop_exec_i,
  input  wire logic                            option_clear_load_i,
  input  wire logic                            watchdog_active_i,
  input  wire logic                            alu_flag_we_i,
  input  wire logic                            alu_carry_i,
  input  wire logic                            alu_zero_i,
  output irq_power_pkg::seq_cmd_type           seq_cmd_o,
  output logic                                 carry_o,
  output logic                                 zero_o,
  output logic                                 core_halt_o,
  output logic                                 osc_run_o,
  output logic                                 resume_o
);
  // ****************************************************************
  // Option register and APB slave
  // ****************************************************************
  logic [7:0] option_q;
  logic       apb_wr;
  logic       addr_ok;
  logic [7:0] status;

  assign pready_o = 1'b1;
  assign addr_ok  = (paddr_i == irq_power_pkg::OPTION_ADDR) ||
                    (paddr_i == irq_power_pkg::STATUS_ADDR);
  assign apb_wr   = psel_i && penable_i && pwrite_i && pstrb_i[0] &&
                    (paddr_i == irq_power_pkg::OPTION_ADDR);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      option_q <= irq_power_pkg::OPTION_RESET;
    end else if (apb_wr) begin
      option_q <= pwdata_i[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pslverr_o <= psel_i && !penable_i && !addr_ok;
      // Option register is write-only and reads as zero
      prdata_o  <= (psel_i && !penable_i && !pwrite_i &&
                    paddr_i == irq_power_pkg::STATUS_ADDR) ?
                   {24'h00_0000, status} : 32'h0000_0000;
    end
  end

  logic gen;
  assign gen = option_q[irq_power_pkg::GLOBAL_EN_BIT];

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [PORT_PINS:0] pin_meta_q;
  logic [PORT_PINS:0] pin_sync_q;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_meta_q <= '1;
      pin_sync_q <= '1;
    end else begin
      pin_meta_q <= {nmi_pin_n_i, port_pin_i};
      pin_sync_q <= pin_meta_q;
    end
  end

  // ****************************************************************
  // Source lines
  // ****************************************************************
  logic src1_line;
  logic src2_line;
  logic src3_line;
  logic src4_line;
  logic src2_q;
  logic src1_line_q;
  logic nmi_q;

  assign src1_line = periph_event_i.spi_end_of_transfer &
                     periph_en_i.spi_end_of_transfer;
  // Enabled pins wire-AND onto one line, low when any is low
  assign src2_line = &(pin_sync_q[PORT_PINS-1:0] | ~port_irq_en_i);
  assign src3_line = |({periph_event_i.timer1_overflow_flag,
                        periph_event_i.lowfreq_osc_event,
                        periph_event_i.reload_timer_overflow,
                        periph_event_i.reload_timer_compare,
                        periph_event_i.reload_timer_input_edge} &
                       {periph_en_i.timer1_overflow_flag,
                        periph_en_i.lowfreq_osc_event,
                        periph_en_i.reload_timer_overflow,
                        periph_en_i.reload_timer_compare,
                        periph_en_i.reload_timer_input_edge});
  assign src4_line = |({periph_event_i.adc_end_of_conversion,
                        periph_event_i.serial_byte_received,
                        periph_event_i.serial_byte_sent} &
                       {periph_en_i.adc_end_of_conversion,
                        periph_en_i.serial_byte_received,
                        periph_en_i.serial_byte_sent});

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      src1_line_q <= 1'b0;
      src2_q      <= 1'b1;
      nmi_q       <= 1'b1;
    end else begin
      src1_line_q <= src1_line;
      src2_q      <= src2_line;
      nmi_q       <= pin_sync_q[PORT_PINS];
    end
  end

  logic edge1;
  logic edge2;
  logic edge_nmi;
  assign edge1    = src1_line && !src1_line_q;
  assign edge2    = option_q[irq_power_pkg::EDGE_POL_BIT] ?
                    (src2_line && !src2_q) : (!src2_line && src2_q);
  assign edge_nmi = !pin_sync_q[PORT_PINS] && nmi_q;

  // ****************************************************************
  // Request latches
  // ****************************************************************
  logic       lat_nmi_q;
  logic       lat1_q;
  logic       lat2_q;
  logic [4:0] clr_src;
  logic       level1;

  assign level1 = option_q[irq_power_pkg::LEVEL_SEL_BIT];

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lat_nmi_q <= 1'b0;
      lat1_q    <= 1'b0;
      lat2_q    <= 1'b0;
    end else begin
      lat_nmi_q <= edge_nmi || (lat_nmi_q && !clr_src[0]);
      lat1_q    <= !level1 && (edge1 || (lat1_q && !clr_src[1]));
      lat2_q    <= edge2 || (lat2_q && !clr_src[2]);
    end
  end

  logic [4:0] req;
  assign req = {src4_line, src3_line, lat2_q,
                level1 ? src1_line : lat1_q, lat_nmi_q};

  // ****************************************************************
  // Mode, acceptance and priority
  // ****************************************************************
  irq_power_pkg::state_type    state_q;
  irq_power_pkg::flag_set_type mode_q;
  irq_power_pkg::flag_set_type act_set_q;
  irq_power_pkg::flag_set_type nmi_ret_mode_q;
  irq_power_pkg::flag_set_type nmi_ret_set_q;
  logic       glitch_q;
  logic [1:0] load_cnt_q;
  logic       mask_ok;
  logic       nmi_ok;
  logic       sample;
  logic       accept;
  logic [4:0] pick;
  logic       wake_any;

  function automatic logic [4:0] first_one(input logic [4:0] r);
    logic [4:0] p;
    p = 5'h00;
    for (int i = 4; i >= 0; i--) begin
      if (r[i]) begin
        p = 5'h00;
        p[i] = 1'b1;
      end
    end
    return p;
  endfunction

  assign mask_ok = (gen || glitch_q) && mode_q == irq_power_pkg::SET_NORMAL
                   && |req[4:1];
  assign nmi_ok  = req[0] && mode_q != irq_power_pkg::SET_NMI;
  // Sample at instruction end or on a serving wake
  assign sample  = (state_q == irq_power_pkg::ST_RUN && instr_end_i) ||
                   (state_q == irq_power_pkg::ST_WAKE &&
                    mode_q == irq_power_pkg::SET_NORMAL);
  assign accept  = sample && (nmi_ok || mask_ok);
  assign pick    = nmi_ok ? 5'h01 : first_one({req[4:1], 1'b0});
  assign clr_src = accept ? pick : 5'h00;

  // Request that arrives early in the option-clear load
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      load_cnt_q <= 2'h0;
      glitch_q   <= 1'b0;
    end else begin
      load_cnt_q <= option_clear_load_i ?
                    load_cnt_q + ((load_cnt_q != 2'h3) ? 2'h1 : 2'h0) : 2'h0;
      if (accept || (sample && !glitch_q)) begin
        glitch_q <= 1'b0;
      end else if (option_clear_load_i && load_cnt_q < irq_power_pkg::GLITCH_CYCLES
                   && |req[4:1] && gen && mode_q == irq_power_pkg::SET_NORMAL) begin
        glitch_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Flag sets
  // ****************************************************************
  logic [2:0] carry_q;
  logic [2:0] zero_q;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      carry_q <= 3'h0;
      zero_q  <= 3'h0;
    end else if (alu_flag_we_i) begin
      for (int i = 0; i < 3; i++) begin
        if (act_set_q[i]) begin
          carry_q[i] <= alu_carry_i;
          zero_q[i]  <= alu_zero_i;
        end
      end
    end
  end

  assign carry_o = |(carry_q & act_set_q);
  assign zero_o  = |(zero_q & act_set_q);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_q         <= irq_power_pkg::SET_NORMAL;
      act_set_q      <= irq_power_pkg::SET_NORMAL;
      nmi_ret_mode_q <= irq_power_pkg::SET_NORMAL;
      nmi_ret_set_q  <= irq_power_pkg::SET_NORMAL;
    end else if (accept && nmi_ok) begin
      mode_q         <= irq_power_pkg::SET_NMI;
      act_set_q      <= irq_power_pkg::SET_NMI;
      nmi_ret_mode_q <= mode_q;
      nmi_ret_set_q  <= act_set_q;
    end else if (accept) begin
      mode_q    <= irq_power_pkg::SET_IRQ;
      act_set_q <= glitch_q ? irq_power_pkg::SET_NORMAL :
                   irq_power_pkg::SET_IRQ;
    end else if (return_from_interrupt_i &&
                 state_q == irq_power_pkg::ST_RUN) begin
      if (mode_q == irq_power_pkg::SET_NMI) begin
        mode_q    <= nmi_ret_mode_q;
        act_set_q <= nmi_ret_set_q;
      end else begin
        mode_q    <= irq_power_pkg::SET_NORMAL;
        act_set_q <= irq_power_pkg::SET_NORMAL;
      end
    end
  end

  // ****************************************************************
  // Sequencer commands
  // ****************************************************************
  logic [11:0] vec_q;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      seq_cmd_o <= '0;
      vec_q     <= irq_power_pkg::VEC_NMI;
    end else begin
      seq_cmd_o.push    <= accept;
      seq_cmd_o.pop     <= return_from_interrupt_i &&
                           state_q == irq_power_pkg::ST_RUN &&
                           mode_q != irq_power_pkg::SET_NORMAL;
      seq_cmd_o.load    <= state_q == irq_power_pkg::ST_VEC;
      seq_cmd_o.load_pc <= vec_q;
      if (accept) begin
        seq_cmd_o.push_pc <= pc_i;
        vec_q <= pick[0] ? irq_power_pkg::VEC_NMI  :
                 pick[1] ? irq_power_pkg::VEC_SRC1 :
                 pick[2] ? irq_power_pkg::VEC_SRC2 :
                 pick[3] ? irq_power_pkg::VEC_SRC3 : irq_power_pkg::VEC_SRC4;
      end
    end
  end

  // ****************************************************************
  // Wait and stop control
  // ****************************************************************
  localparam int CW = $clog2(STAB_CYCLES + 1);
  logic [CW-1:0] stab_q;
  logic          go_low;
  logic          wake_ext;

  // Low-power entry refused while an enabled request is pending
  assign go_low   = state_q == irq_power_pkg::ST_RUN && !accept &&
                    !(gen && |req);
  assign wake_any = gen && |req;
  assign wake_ext = gen && (req[0] || req[2]);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= irq_power_pkg::ST_RUN;
      stab_q  <= '0;
    end else begin
      case (state_q)
        irq_power_pkg::ST_RUN: begin
          if (accept) begin
            state_q <= irq_power_pkg::ST_VEC;
          end else if (go_low && stop_exec_i && !watchdog_active_i) begin
            state_q <= irq_power_pkg::ST_STOP;
          end else if (go_low && (wait_exec_i || stop_exec_i)) begin
            state_q <= irq_power_pkg::ST_WAIT;
          end
        end
        irq_power_pkg::ST_VEC: begin
          state_q <= irq_power_pkg::ST_RUN;
        end
        irq_power_pkg::ST_WAIT: begin
          if (wake_any) begin
            state_q <= irq_power_pkg::ST_WAKE;
          end
        end
        irq_power_pkg::ST_STOP: begin
          if (wake_ext) begin
            state_q <= irq_power_pkg::ST_STAB;
            stab_q  <= CW'(STAB_CYCLES);
          end
        end
        irq_power_pkg::ST_STAB: begin
          stab_q <= stab_q - CW'(1);
          if (stab_q == CW'(1)) begin
            state_q <= irq_power_pkg::ST_WAKE;
          end
        end
        irq_power_pkg::ST_WAKE: begin
          // Normal mode serves the waker; other modes simply resume
          state_q <= accept ? irq_power_pkg::ST_VEC :
                     irq_power_pkg::ST_RUN;
        end
        default: begin
          state_q <= irq_power_pkg::ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      resume_o <= 1'b0;
    end else begin
      resume_o <= state_q == irq_power_pkg::ST_WAKE;
    end
  end

  assign core_halt_o = state_q != irq_power_pkg::ST_RUN;
  assign osc_run_o   = state_q != irq_power_pkg::ST_STOP;
  assign status      = {lat2_q, lat1_q, lat_nmi_q,
                        state_q == irq_power_pkg::ST_STOP,
                        state_q == irq_power_pkg::ST_WAIT, mode_q};

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_push_pc;
    @(posedge clk_i) disable iff (!reset_n_i)
    accept |=> seq_cmd_o.push && seq_cmd_o.push_pc == $past(pc_i);
  endproperty
  a_push_pc: assert property (p_push_pc) else $error("pc not pushed");

  property p_vector;
    @(posedge clk_i) disable iff (!reset_n_i)
    (accept && nmi_ok) |=> ##1 seq_cmd_o.load &&
      seq_cmd_o.load_pc == irq_power_pkg::VEC_NMI;
  endproperty
  a_vector: assert property (p_vector) else $error("bad nmi vector");

  property p_block_mask;
    @(posedge clk_i) disable iff (!reset_n_i)
    (mode_q != irq_power_pkg::SET_NORMAL && !req[0]) |-> !accept;
  endproperty
  a_block_mask: assert property (p_block_mask) else $error("nested maskable");

  property p_irq_set;
    @(posedge clk_i) disable iff (!reset_n_i)
    (accept && !nmi_ok && !glitch_q) |=> act_set_q == irq_power_pkg::SET_IRQ;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("flags not swapped");

  property p_latch_clr;
    @(posedge clk_i) disable iff (!reset_n_i)
    (accept && nmi_ok && !edge_nmi) |=> !lat_nmi_q;
  endproperty
  a_latch_clr: assert property (p_latch_clr) else $error("latch kept");

  property p_wait_fast;
    @(posedge clk_i) disable iff (!reset_n_i)
    (state_q == irq_power_pkg::ST_WAIT && wake_any) |=> ##1 resume_o;
  endproperty
  a_wait_fast: assert property (p_wait_fast) else $error("wait exit slow");

  property p_no_wake;
    @(posedge clk_i) disable iff (!reset_n_i)
    (state_q == irq_power_pkg::ST_STOP && !gen) |=> state_q == irq_power_pkg::ST_STOP;
  endproperty
  a_no_wake: assert property (p_no_wake) else $error("woke with gen low");

  property p_stab;
    @(posedge clk_i) disable iff (!reset_n_i)
    (state_q == irq_power_pkg::ST_STAB && stab_q > CW'(1))
      |=> state_q == irq_power_pkg::ST_STAB;
  endproperty
  a_stab: assert property (p_stab) else $error("stop exit early");

  property p_return_from_interrupt;
    @(posedge clk_i) disable iff (!reset_n_i)
    (return_from_interrupt_i && state_q == irq_power_pkg::ST_RUN && !accept &&
     mode_q == irq_power_pkg::SET_IRQ) |=> act_set_q == irq_power_pkg::SET_NORMAL
      && seq_cmd_o.pop;
  endproperty
  a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("return not restored");
endmodule
`default_nettype wire

// ---- hdl/irq_power_pkg.sv ----
// Constants and types for the core interrupt and power-save block
// ****************************************************************
// ****************************************************************
package irq_power_pkg;
  localparam logic [7:0]  OPTION_ADDR   = 8'hc8;
  localparam logic [7:0]  STATUS_ADDR   = 8'hcc;
  localparam logic [7:0]  OPTION_RESET  = 8'h00;
  localparam int          LEVEL_SEL_BIT = 6;
  localparam int          EDGE_POL_BIT  = 5;
  localparam int          GLOBAL_EN_BIT = 4;
  localparam logic [11:0] VEC_NMI       = 12'hffc;
  localparam logic [11:0] VEC_SRC1      = 12'hff6;
  localparam logic [11:0] VEC_SRC2      = 12'hff4;
  localparam logic [11:0] VEC_SRC3      = 12'hff2;
  localparam logic [11:0] VEC_SRC4      = 12'hff0;
  localparam logic [1:0]  GLITCH_CYCLES = 2'h3;
  localparam int          STAB_DEFAULT  = 2048;

  typedef enum logic [5:0] {
    ST_RUN  = 6'b000001,
    ST_VEC  = 6'b000010,
    ST_WAIT = 6'b000100,
    ST_STOP = 6'b001000,
    ST_STAB = 6'b010000,
    ST_WAKE = 6'b100000
  } state_type;

  typedef enum logic [2:0] {
    SET_NORMAL = 3'b001,
    SET_IRQ    = 3'b010,
    SET_NMI    = 3'b100
  } flag_set_type;

  typedef struct packed {
    logic timer1_overflow_flag;
    logic lowfreq_osc_event;
    logic reload_timer_overflow;
    logic reload_timer_compare;
    logic reload_timer_input_edge;
    logic adc_end_of_conversion;
    logic serial_byte_received;
    logic serial_byte_sent;
    logic spi_end_of_transfer;
  } periph_event_type;

  typedef struct packed {
    logic       push;
    logic [11:0] push_pc;
    logic       pop;
    logic       load;
    logic [11:0] load_pc;
  } seq_cmd_type;
endpackage

// ---- test/periph_model.sv ----
// Stand-in for the peripherals and pins that raise interrupt requests
`timescale 1ns/100ps
`default_nettype none
module periph_model (
  // Clock
  input  wire logic                       clk_i,
  // Request sources
  output logic                            nmi_pin_n_o,
  output logic [21:0]                     port_pin_o,
  output irq_power_pkg::periph_event_type event_o
);
  // Pins idle high through their pull-ups
  initial begin
    nmi_pin_n_o = 1'b1;
    port_pin_o  = '1;
    event_o     = '0;
  end

  task automatic nmi_pulse(input int hold);
    @(posedge clk_i);
    nmi_pin_n_o <= 1'b0;
    repeat (hold) @(posedge clk_i);
    nmi_pin_n_o <= 1'b1;
  endtask

  task automatic ev_set(input int idx, input logic v);
    @(posedge clk_i);
    event_o[idx] <= v;
  endtask

  task automatic pin(input int idx, input logic v);
    @(posedge clk_i);
    port_pin_o[idx] <= v;
  endtask
endmodule
`default_nettype wire

// ---- test/tb_core_irq_power.sv ----
// Self-checking bench for the interrupt and power-save block
`timescale 1ns/100ps
`default_nettype none
module tb_core_irq_power;
  logic        clk_i, reset_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic        nmi_n, cy, zr, ocl, wd, resume;
  logic [4:0]  go;
  logic        carry_o, zero_o, halt, osc, err;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [21:0] pin;
  logic [11:0] pc_i;
  irq_power_pkg::periph_event_type ev;
  irq_power_pkg::seq_cmd_type      cmd;
  int          n_fail, comparisons, seed, cur, n, psh, res;
  int          stk[$];
  // Bit positions of the sequencer strobes in go
  localparam int P_END = 0, P_RFI = 1, P_WAIT = 2, P_STOP = 3, P_WE = 4;

  core_irq_power #(.STAB_CYCLES(8)) dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(4'hf),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o),
    .nmi_pin_n_i(nmi_n), .port_pin_i(pin), .port_irq_en_i(22'h3fffff),
    .periph_event_i(ev), .periph_en_i('1), .instr_end_i(go[P_END]), .pc_i(pc_i),
    .return_from_interrupt_i(go[P_RFI]), .wait_exec_i(go[P_WAIT]), .stop_exec_i(go[P_STOP]),
    .option_clear_load_i(ocl), .watchdog_active_i(wd), .alu_flag_we_i(go[P_WE]),
    .alu_carry_i(cy), .alu_zero_i(zr), .seq_cmd_o(cmd), .carry_o(carry_o),
    .zero_o(zero_o), .core_halt_o(halt), .osc_run_o(osc), .resume_o(resume));

  periph_model pm (.clk_i(clk_i), .nmi_pin_n_o(nmi_n), .port_pin_o(pin), .event_o(ev));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic bad;
    n_fail++;
    end_of_test();
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_i);
      if (pready_o === 1'b1) break;
    end
    if (k == 50) bad();
    // Data and error taken at the completing edge
    rd = prdata_o;
    err = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
  endtask

  task automatic pulse(input int i);
    @(posedge clk_i);
    go[i] <= 1'b1;
    @(posedge clk_i);
    go[i] <= 1'b0;
  endtask

  task automatic mode;
    apb(1'b0, irq_power_pkg::STATUS_ADDR, 32'h0);
    chk("mode", cur, {29'h0, rd[2:0]});
  endtask

  task automatic kick;
    pc_i <= 12'($random(seed));
    pulse(P_END);
  endtask

  // Waits for the vector load, checking the stacked address on the way
  task automatic take(input logic [11:0] v, input int m, input int lim);
    psh = 0;
    res = 0;
    for (n = 0; n < lim; n++) begin
      #1;
      if (cmd.push === 1'b1) begin
        psh = 1;
        chk("push_pc", pc_i, cmd.push_pc);
      end
      if (resume === 1'b1) res = 1;
      if (cmd.load === 1'b1) break;
      @(posedge clk_i);
    end
    if (n == lim) bad();
    chk("push", 1, psh);
    chk("load_pc", v, cmd.load_pc);
    stk.push_back(cur);
    cur = m;
    mode();
  endtask

  task automatic ret;
    pulse(P_RFI);
    #1;
    chk("pop", 1, cmd.pop);
    cur = stk.pop_back();
    mode();
  endtask

  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    {reset_n_i, psel_i, penable_i, pwrite_i, go, ocl, wd} = '0;
    {cy, zr, paddr_i, pwdata_i, pc_i} = '0;
    seed = 32'h6215;
    cur = 1;
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    apb(1'b0, irq_power_pkg::OPTION_ADDR, 32'h0);
    chk("option", 0, rd);
    mode();
    apb(1'b0, 8'hd0, 32'h0);
    chk("slverr", 1, err);
    {cy, zr} <= 2'b11;
    pulse(P_WE);
    #1;
    chk("carry", 1, carry_o);
    chk("zero", 1, zero_o);
    pm.ev_set(0, 1'b1);
    kick();
    mode();
    apb(1'b1, irq_power_pkg::OPTION_ADDR, 32'h10);
    kick();
    take(irq_power_pkg::VEC_SRC1, 2, 8);
    chk("resume", 0, res);
    chk("carry", 0, carry_o);
    chk("zero", 0, zero_o);
    pm.ev_set(8, 1'b1);
    kick();
    mode();
    pm.nmi_pulse(3);
    repeat (4) @(posedge clk_i);
    kick();
    take(irq_power_pkg::VEC_NMI, 4, 8);
    ret();
    ret();
    chk("carry", 1, carry_o);
    // Pending request while the option clear is under way
    ocl <= 1'b1;
    apb(1'b1, irq_power_pkg::OPTION_ADDR, 32'h0);
    ocl <= 1'b0;
    kick();
    take(irq_power_pkg::VEC_SRC3, 2, 8);
    chk("carry", 1, carry_o);
    pm.ev_set(8, 1'b0);
    ret();
    apb(1'b1, irq_power_pkg::OPTION_ADDR, 32'h10);
    pulse(P_WAIT);
    #1;
    chk("halt", 2'b11, {halt, osc});
    pm.ev_set(1, 1'b1);
    take(irq_power_pkg::VEC_SRC4, 2, 6);
    chk("resume", 1, res);
    chk("wake", 1, 32'(n <= 3));
    pm.ev_set(1, 1'b0);
    ret();
    pulse(P_STOP);
    #1;
    chk("osc", 0, osc);
    pm.ev_set(8, 1'b1);
    repeat (20) @(posedge clk_i);
    #1;
    chk("halt", 1, halt);
    pm.pin(0, 1'b0);
    take(irq_power_pkg::VEC_SRC2, 2, 40);
    chk("stab", 1, 32'(n >= 8));
    chk("resume", 1, res);
    pm.ev_set(8, 1'b0);
    pm.pin(0, 1'b1);
    ret();
    // Watchdog running turns stop into wait
    wd <= 1'b1;
    pulse(P_STOP);
    #1;
    chk("osc", 2'b11, {halt, osc});
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    wd <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk("halt", 2'b01, {halt, osc});
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    cur = 1;
    mode();
    // Enable low after reset: the non-maskable edge must not wake stop
    pulse(P_STOP);
    pm.nmi_pulse(3);
    repeat (6) @(posedge clk_i);
    #1;
    chk("halt", 2'b10, {halt, osc});
    end_of_test();
  end
endmodule
`default_nettype wire
